// >>> logic/ptc_pkg.sv
package ptc_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 16;

    // Register byte offsets on the bus.
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_TCONST  = 8'h04;
    localparam logic [7:0]  OFF_PRESET  = 8'h08;
    localparam logic [7:0]  OFF_STATUS  = 8'h0C;
    localparam logic [7:0]  OFF_ELAPSED = 8'h10;
    localparam logic [7:0]  OFF_COUNT   = 8'h14;

    // Status register bit positions.
    localparam int STAT_TIMER  = 0;
    localparam int STAT_ZERO   = 1;
    localparam int STAT_ACTIVE = 2;
    localparam int STAT_LIMIT  = 3;

    // Bus encodings.
    localparam logic [1:0]  HTRANS_IDLE = 2'h0;
    localparam logic        HRESP_OKAY  = 1'b0;

    // Input levels written by the control program, bit 7 down to bit 0.
    typedef struct packed {
        logic count_load;
        logic counter_gate;
        logic count_decrement;
        logic count_increment;
        logic timer_clear;
        logic timer_run_gate;
        logic pulse_limit_trigger;
        logic deassert_delay_trigger;
    } ptc_ctrl_t;

    localparam int        CTRL_W     = 8;
    localparam ptc_ctrl_t CTRL_RST   = 8'h04;
    localparam logic [31:0] TCONST_RST  = 32'h0000_0000;
    localparam logic [31:0] PRESET_RST  = 32'h0000_0000;
    localparam logic [31:0] ELAPSED_RST = 32'h0000_0000;
    localparam logic [31:0] COUNT_RST   = 32'h0000_0000;
    localparam logic [31:0] COUNT_MAX   = 32'h7FFF_FFFF;
    localparam logic [31:0] COUNT_MIN   = 32'h8000_0001;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN  = 3'b100
    } ptc_state_t;

    typedef enum logic [1:0] {
        MODE_DEASSERT = 2'b01,
        MODE_LIMIT    = 2'b10
    } ptc_mode_t;

endpackage : ptc_pkg

// >>> logic/ptc_edge.sv
`timescale 1ns/1ps
module ptc_edge
    import ptc_pkg::*;
#(
    parameter int W = 8
)
(
    // Clock and reset.
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Levels and their edges.
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] prev_q;

    // Level seen on the previous clock edge.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prev_q <= '0;
        else
            prev_q <= level;
    end

    // Edges compare the present level with the previous one.
    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;

endmodule : ptc_edge

// >>> logic/ptc_timer_counter.sv
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Deassert-delay rise with gate high, clear low: status high, no counting yet.
// (R2) Deassert-delay mode starts elapsed time from zero at trigger fall.
// (R3) Elapsed reaching the time constant stops timing and drops status.
// (R4) Elapsed time holds after timing ends until next trigger rise.
// (R5) Deassert-delay rise before expiry re-triggers: status high, elapsed zero.
// (R6) Pulse-limit rise with gate high, clear low: status high, timing from zero.
// (R7) Pulse-limit fall before expiry stops timing, drops status, keeps elapsed.
// (R8) Ended pulse-limit timer idles until a new trigger rise.
// (R9) Clear rise drops status, zeroes elapsed, deactivates the timer.
// (R10) Run gate low pauses elapsed time; high resumes from held value.
// (R11) Count is signed 32-bit within plus or minus 2147483647; a preset of -2147483648 is still loaded as is.
// (R12) Each increment rise adds one to the count.
// (R13) Each decrement rise subtracts one from the count.
// (R14) Count steps only with counter gate high; otherwise increment and decrement edges ignored. Load ignores the gate.
// (R15) Load rise loads the count with the preset value.
// (R16) Zero flag is one exactly when the count is zero.
// (R17) Boolean read gives the zero flag, arithmetic read the full count.
// (R18) Time constant is unsigned 0 to 4294967295 milliseconds.
// (R19) Reset clears timer status and elapsed time.
// (R20) Timer run gate defaults high.
// (R21) Simultaneous increment and decrement leave the count unchanged.
// (R22) Edges compare present level with the level one clock earlier.
module ptc_timer_counter
    import ptc_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
)
(
    // Clock and reset.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    // Resource status.
    output logic                   timer_status,
    output logic                   counter_zero
);

    ptc_ctrl_t         ctrl_q;
    logic [31:0]       tconst_q;
    logic [31:0]       preset_q;
    logic [31:0]       elapsed_q;
    logic [31:0]       count_q;
    logic [TICK_W-1:0] tick_q;
    ptc_state_t        state_q;
    ptc_mode_t         mode_q;
    logic              wr_pend_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic              ahb_take;
    logic [ADDR_W-1:0] addr_lo;
    logic [31:0]       rd_val;
    logic [CTRL_W-1:0] rise;
    logic [CTRL_W-1:0] fall;
    logic              can_trig;
    logic              dd_rise;
    logic              dd_fall;
    logic              pl_rise;
    logic              pl_fall;
    logic              clr_rise;
    logic              tick_end;
    logic              expired;
    logic              cnt_up;
    logic              cnt_dn;

    // Bus side: a transfer is taken when selected, htrans bit 1 is set (not idle, not busy) and the bus is ready.
    assign ahb_take = hsel && hready && htrans[1];
    assign addr_lo  = haddr[ADDR_W-1:0];

    // Edge detection on all program-driven levels, same clock, no synchroniser.
    ptc_edge #(.W(CTRL_W)) u_edge
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .level   (ctrl_q),
        .rise    (rise),
        .fall    (fall)
    ); // R22

    // The run gate leaves reset high while the edge copy leaves reset low, so
    // its rise bit pulses once after reset. Only trigger, clear and count bits
    // are decoded as edges, so that pulse can never start or move anything.

    // Activation needs run gate high and clear low at the moment of the edge.
    assign can_trig = ctrl_q.timer_run_gate && !ctrl_q.timer_clear; // R1 R6
    assign dd_rise  = rise[0] && can_trig;
    assign pl_rise  = rise[1] && can_trig;
    assign dd_fall  = fall[0];
    assign pl_fall  = fall[1];
    assign clr_rise = rise[3];
    assign cnt_up   = rise[4] && ctrl_q.counter_gate; // R14
    assign cnt_dn   = rise[5] && ctrl_q.counter_gate; // R14
    assign tick_end = (tick_q == TICK_W'(TICK_CYC - 1));
    assign expired  = (elapsed_q >= tconst_q); // R3

    // Read multiplexer; unmapped offsets read as zero.
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (addr_lo)
            OFF_CTRL:    rd_val = {24'h00_0000, ctrl_q};
            OFF_TCONST:  rd_val = tconst_q;
            OFF_PRESET:  rd_val = preset_q;
            OFF_STATUS:
            begin
                rd_val[STAT_TIMER]  = timer_status;
                rd_val[STAT_ZERO]   = counter_zero; // R17
                rd_val[STAT_ACTIVE] = (state_q != ST_IDLE);
                rd_val[STAT_LIMIT]  = (mode_q == MODE_LIMIT);
            end
            OFF_ELAPSED: rd_val = elapsed_q;
            OFF_COUNT:   rd_val = count_q; // R17
            default:     rd_val = 32'h0000_0000;
        endcase
    end

    // Zero-wait slave: ready and response never change, read data is
    // registered at the address phase so it stands through the data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            if (ahb_take && !hwrite)
                hrdata <= rd_val;
        end
    end

    // Write address is held for the data phase that follows.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end
        else
        begin
            if (hready)
                wr_pend_q <= ahb_take && hwrite;
            if (ahb_take && hwrite)
                wr_addr_q <= addr_lo;
        end
    end

    // Program-writable registers. The run gate comes out of reset high so
    // that a program which never touches it still gets a running timer.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q   <= CTRL_RST; // R20
            tconst_q <= TCONST_RST;
            preset_q <= PRESET_RST;
        end
        else if (wr_pend_q)
        begin
            case (wr_addr_q)
                OFF_CTRL:   ctrl_q   <= ptc_ctrl_t'(hwdata[CTRL_W-1:0]);
                OFF_TCONST: tconst_q <= hwdata; // R18
                OFF_PRESET: preset_q <= hwdata;
                default:    ctrl_q   <= ctrl_q;
            endcase
        end
    end

    // Timer sequencing. Clear outranks triggers; a deassert-delay rise is
    // examined before a pulse-limit rise when both land on one edge.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q      <= ST_IDLE;
            mode_q       <= MODE_DEASSERT;
            timer_status <= 1'b0; // R19
        end
        else if (clr_rise)
        begin
            state_q      <= ST_IDLE; // R9
            timer_status <= 1'b0;
        end
        else if (dd_rise)
        begin
            state_q      <= ST_HOLD; // R1 R5
            mode_q       <= MODE_DEASSERT;
            timer_status <= 1'b1;
        end
        else if (pl_rise)
        begin
            state_q      <= ST_RUN; // R6
            mode_q       <= MODE_LIMIT;
            timer_status <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    state_q <= ST_IDLE; // R8
                ST_HOLD:
                    if (dd_fall)
                        state_q <= ST_RUN; // R2
                ST_RUN:
                    if (mode_q == MODE_LIMIT && pl_fall)
                    begin
                        state_q      <= ST_IDLE; // R7
                        timer_status <= 1'b0;
                    end
                    else if (expired)
                    begin
                        state_q      <= ST_IDLE; // R3
                        timer_status <= 1'b0;
                    end
                default:
                begin
                    state_q      <= ST_IDLE;
                    timer_status <= 1'b0;
                end
            endcase
        end
    end

    // Elapsed time in milliseconds. It is zeroed by every activation, by a clear rise and
    // by the fall that starts deassert-delay timing; it counts while running and otherwise holds.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            elapsed_q <= ELAPSED_RST; // R19
            tick_q    <= '0;
        end
        else if (clr_rise || dd_rise || pl_rise)
        begin
            elapsed_q <= ELAPSED_RST; // R5 R6 R9
            tick_q    <= '0;
        end
        else if (state_q == ST_HOLD && dd_fall)
        begin
            elapsed_q <= ELAPSED_RST; // R2
            tick_q    <= '0;
        end
        else if (state_q == ST_RUN && !expired && ctrl_q.timer_run_gate
                 && !(mode_q == MODE_LIMIT && pl_fall))
        begin
            // Pausing keeps the partial millisecond, so resume is seamless.
            if (tick_end)
            begin
                tick_q    <= '0;
                elapsed_q <= elapsed_q + 32'h0000_0001; // R10
            end
            else
                tick_q <= tick_q + TICK_W'(1);
        end
        // Any other state leaves the elapsed time as it was.
        else
            elapsed_q <= elapsed_q; // R4
    end

    // Up/down counter. Load wins over counting; it ignores the gate. The
    // count saturates inside the symmetric range instead of wrapping, so a
    // stuck count input folds the count over to the opposite sign only by a decrement from a loaded -2147483648.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count_q <= COUNT_RST;
        else if (rise[7])
            count_q <= preset_q; // R15
        else if (cnt_up && cnt_dn)
            count_q <= count_q; // R21
        else if (cnt_up && count_q != COUNT_MAX)
            count_q <= count_q + 32'h0000_0001; // R11 R12
        else if (cnt_dn && count_q != COUNT_MIN)
            count_q <= count_q - 32'h0000_0001; // R11 R13
    end

    // Zero flag follows the next count value so it is in step with it.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            counter_zero <= 1'b1;
        else if (rise[7])
            counter_zero <= (preset_q == 32'h0000_0000); // R16
        else if (cnt_up && !cnt_dn && count_q != COUNT_MAX)
            counter_zero <= (count_q == 32'hFFFF_FFFF); // R16
        else if (cnt_dn && !cnt_up && count_q != COUNT_MIN)
            counter_zero <= (count_q == 32'h0000_0001); // R16
        else
            counter_zero <= (count_q == 32'h0000_0000); // R16
    end

endmodule : ptc_timer_counter

// >>> dv/ptc_timer_counter_asserts.sv
`timescale 1ns/1ps
module ptc_timer_counter_asserts
    import ptc_pkg::*;
(
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus.
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Status.
    input wire logic        timer_status,
    input wire logic        counter_zero
);
    logic      wr_q;
    logic      lim_q;
    ptc_ctrl_t sh_q;
    ptc_ctrl_t pv_q;
    ptc_ctrl_t rs;
    ptc_ctrl_t fl;
    logic      dd_ok;
    logic      pl_ok;
    logic      trig_ok;
    logic      cnt_ev;

    // Shadow of the control levels and their copy one clock older.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            sh_q <= CTRL_RST;
            pv_q <= CTRL_RST;
        end
        else
        begin
            wr_q <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == OFF_CTRL;
            if (wr_q && hready)
                sh_q <= ptc_ctrl_t'(hwdata[7:0]);
            pv_q <= sh_q;
        end

    // Edges and the triggers that are accepted; a clear level blocks any trigger.
    assign rs = ptc_ctrl_t'(sh_q & ~pv_q);
    assign fl = ptc_ctrl_t'(~sh_q & pv_q);
    assign dd_ok = rs.deassert_delay_trigger && sh_q.timer_run_gate && !sh_q.timer_clear;
    assign pl_ok = rs.pulse_limit_trigger && sh_q.timer_run_gate && !sh_q.timer_clear && !dd_ok;
    assign trig_ok = dd_ok || pl_ok;
    assign cnt_ev = rs.count_load
                    || (sh_q.counter_gate && (rs.count_increment || rs.count_decrement));

    // Mode of the last accepted trigger, needed to judge a limit fall.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            lim_q <= 1'b0;
        else if (trig_ok)
            lim_q <= pl_ok;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence lim_fall_s;
        lim_q && fl.pulse_limit_trigger && rs == '0;
    endsequence

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    delay_set_a: assert property (dd_ok |=> timer_status)
        else $error("delay trigger did not raise status");
    limit_set_a: assert property (pl_ok |=> timer_status)
        else $error("limit trigger did not raise status");
    clear_drop_a: assert property (rs.timer_clear |=> !timer_status)
        else $error("clear did not drop status");
    limit_fall_a: assert property (lim_fall_s |=> !timer_status)
        else $error("limit fall did not drop status");
    status_cause_a: assert property ($rose(timer_status) |-> $past(trig_ok))
        else $error("status rose without a trigger");
    zero_cause_a: assert property (!$stable(counter_zero) |-> $past(cnt_ev))
        else $error("zero flag moved without a count event");
    gate_freeze_a: assert property (!sh_q.counter_gate && !rs.count_load
                                    |=> $stable(counter_zero))
        else $error("count moved with gate low");
endmodule : ptc_timer_counter_asserts

// >>> dv/ptc_host.sv
`timescale 1ns/1ps
module ptc_host
    import ptc_pkg::*;
(
    // Clock.
    input wire logic        hclk,
    // Master outputs.
    output logic            hsel,
    output logic [31:0]     haddr,
    output logic [1:0]      htrans,
    output logic            hwrite,
    output logic [2:0]      hsize,
    output logic [31:0]     hwdata,
    // Slave answer and hang flag.
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    output logic            hung
);
    // Quiet bus at time zero.
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        hung = 1'b0;
    end

    // Waits for ready at a rising edge, but never forever.
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        if (n >= 50)
            hung <= 1'b1;
    endtask : wait_rdy

    // One single word transfer; the caller enters just after a rising edge.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        hwdata <= ~d; // Stale data is inverted so it is never mistaken for valid.
    endtask : xfer
endmodule : ptc_host

// >>> dv/ptc_timer_counter_bench.sv
`timescale 1ns/1ps
module ptc_timer_counter_bench
    import ptc_pkg::*;
;
    localparam int TK = 4;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel, hwrite, hready, hresp, hung, timer_status, counter_zero;
    logic [31:0] haddr, hwdata, hrdata, v, e1;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [2:0]  op;
    logic        g;
    logic signed [31:0] cnt_m;
    int          errors = 0;
    int          total_checks = 0;

    always #25 hclk = ~hclk;

    // A short time base keeps the timing scenarios brief.
    ptc_timer_counter #(.TICK_CYC(TK)) ptc_timer_counter_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hrdata(hrdata), .hresp(hresp), .timer_status(timer_status),
        .counter_zero(counter_zero));
    ptc_host ptc_host_inst (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hung(hung));

    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ptc_host_inst.xfer(a, 1'b1, d, v);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
        ptc_host_inst.xfer(a, 1'b0, 32'h0, v);
        chk(v, e, m);
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
    endtask : rdc

    // Status settles one edge after the write lands.
    task automatic st(input logic e);
        repeat (2) @(posedge hclk);
        chk({31'h0, timer_status}, {31'h0, e}, "timer status");
    endtask : st

    // Expected count after one operation: load first, then a saturating step.
    function automatic logic signed [31:0] nxt(input logic signed [31:0] c,
                                               input logic [2:0] o, input logic gt,
                                               input logic signed [31:0] p);
        if (o[2])
            return p;
        if (!gt || o[1] == o[0])
            return c;
        if (o[0])
            return (c == $signed(COUNT_MAX)) ? c : c + 1;
        return (c == $signed(COUNT_MIN)) ? c : c - 1;
    endfunction : nxt

    task automatic cop(input logic [2:0] o, input logic gt, input logic signed [31:0] p);
        wr(OFF_PRESET, p);
        wr(OFF_CTRL, {24'h0, o[2], gt, o[1:0], 4'h4});
        wr(OFF_CTRL, {24'h0, 1'b0, gt, 6'h04});
        cnt_m = nxt(cnt_m, o, gt, p);
        rdc(OFF_COUNT, cnt_m, "count");
        chk({31'h0, counter_zero}, {31'h0, cnt_m == 0}, "zero flag");
    endtask : cop

    // A hung bus ends the run through the same report.
    always @(posedge hung)
    begin
        errors++;
        end_of_test();
    end

    initial
    begin
        void'($urandom(41));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(OFF_CTRL, 32'h4, "ctrl reset");
        rdc(OFF_TCONST, 32'h0, "tconst reset");
        rdc(OFF_PRESET, 32'h0, "preset reset");
        rdc(OFF_STATUS, 32'h2, "status reset");
        rdc(OFF_ELAPSED, 32'h0, "elapsed reset");
        rdc(OFF_COUNT, 32'h0, "count reset");
        wr(8'h18, 32'hFFFFFFFF);
        rdc(8'h18, 32'h0, "unmapped");
        wr(OFF_STATUS, 32'hFF);
        rdc(OFF_STATUS, 32'h2, "status read only");
        $display("test registers done");
        wr(OFF_TCONST, 32'd3);
        wr(OFF_CTRL, 32'h05);
        st(1'b1);
        rdc(OFF_STATUS, 32'h7, "delay holding");
        repeat (20) @(posedge hclk);
        rdc(OFF_ELAPSED, 32'h0, "no count while high");
        wr(OFF_CTRL, 32'h04);
        wr(OFF_CTRL, 32'h05);
        st(1'b1);
        rdc(OFF_ELAPSED, 32'h0, "retrigger zero");
        wr(OFF_CTRL, 32'h04);
        st(1'b1);
        repeat (30) @(posedge hclk);
        st(1'b0);
        rdc(OFF_ELAPSED, 32'd3, "delay expiry");
        $display("test delay done");
        wr(OFF_TCONST, 32'd5);
        wr(OFF_CTRL, 32'h06);
        st(1'b1);
        rdc(OFF_STATUS, 32'hF, "limit running");
        wr(OFF_CTRL, 32'h02);
        ptc_host_inst.xfer(OFF_ELAPSED, 1'b0, 32'h0, e1);
        repeat (40) @(posedge hclk);
        rdc(OFF_ELAPSED, e1, "paused");
        wr(OFF_CTRL, 32'h06);
        wr(OFF_CTRL, 32'h04);
        st(1'b0);
        ptc_host_inst.xfer(OFF_ELAPSED, 1'b0, 32'h0, e1);
        chk({31'h0, e1 < 5}, 32'h1, "fall before expiry");
        repeat (30) @(posedge hclk);
        rdc(OFF_ELAPSED, e1, "kept after fall");
        for (int i = 0; i < 3; i++)
        begin
            v = $urandom_range(1, 6);
            e1 = v;
            wr(OFF_TCONST, e1);
            wr(OFF_CTRL, 32'h06);
            st(1'b1);
            repeat (e1 * TK + 12) @(posedge hclk);
            st(1'b0);
            rdc(OFF_ELAPSED, e1, "limit expiry");
            repeat (20) @(posedge hclk);
            st(1'b0);
            wr(OFF_CTRL, 32'h04);
        end
        wr(OFF_CTRL, 32'h06);
        wr(OFF_CTRL, 32'h0E);
        st(1'b0);
        rdc(OFF_ELAPSED, 32'h0, "clear zeroes");
        wr(OFF_CTRL, 32'h06);
        repeat (20) @(posedge hclk);
        st(1'b0);
        wr(OFF_CTRL, 32'h04);
        $display("test limit and clear done");
        cnt_m = 0;
        cop(3'b100, 1'b0, $signed(COUNT_MAX));
        cop(3'b001, 1'b1, 32'sd0);
        cop(3'b100, 1'b1, $signed(COUNT_MIN));
        cop(3'b010, 1'b1, 32'sd0);
        for (int i = 0; i < 60; i++)
        begin
            op = 3'($urandom_range(1, 7));
            g = 1'($urandom);
            v = $urandom_range(0, 4) - 2;
            cop(op, g, v);
        end
        $display("test counter done");
        end_of_test();
    end
endmodule : ptc_timer_counter_bench

bind ptc_timer_counter ptc_timer_counter_asserts ptc_timer_counter_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .timer_status(timer_status), .counter_zero(counter_zero));
